/* verilog/radio_host_spi_port.sv */
// Serial register port, power sequencer, timekeeper and clock pin control
`timescale 1ns/1ps
`default_nettype none

//Contract
// - Mode 0: sample rising, change falling
// - Slave only, eight-bit byte units
// - Non-burst transaction is command plus one byte
// - Address is command bits five to zero
// - Bit six set: store data byte
// - Bit six clear: shift register out
// - Bit seven selects multi-byte FIFO burst
// - Port silent in off state or while chip reset low
// - Five power states, active to off
// - Power steps never skip a level, except into off
// - Automatic sleep and wake conditions
// - Power-off pin high forces off state
// - Chip reset low resets the registers, not the power state
// - Interrupt on enabled events
// - Timekeeper runs except off, wakes device
// - Clock pins configurable as inputs
// - Clock pins grounded until configured
// - One-volt rail only idle and active
// - Registers default after reset or off
// - Deep sleep exit needs stable slow clock
module radio_host_spi_port #(
   parameter int T_OFF_DEEP = radio_port_pkg::T_OFF_DEEP_CYC,
   parameter int T_DEEP_SHALLOW = radio_port_pkg::T_DEEP_SHALLOW_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Host pins
   input wire logic chip_reset_low,
   input wire logic shutdown_pin,
   input wire logic csn_low,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   output logic irq,
   // Clock pins
   input wire logic slow_clock_pin_in,
   output logic slow_clock_pin_out,
   output logic slow_clock_pin_oe_n,
   input wire logic fast_clock_pin_in,
   output logic fast_clock_pin_out,
   output logic fast_clock_pin_oe_n,
   input wire logic slow_osc_in,
   // Core events
   input wire logic pkt_rx_evt,
   input wire logic tx_done_evt,
   // FIFO byte streams
   output logic [7:0] tx_byte,
   output logic tx_push,
   input wire logic [7:0] rx_byte,
   output logic rx_pop,
   // Status
   output logic [2:0] power_level,
   output logic rail_1v_on
);
   localparam int NS = 7;

   // Two-flop synchronisers
   logic [NS-1:0] sync1_r, sync2_r;
   logic csn_s, sck_s, mosi_s, chip_reset_low_s, shut_s, slow_pin_s, osc_s;
   always_ff @(posedge clk_sys) begin
      sync1_r <= {fast_clock_pin_in, slow_osc_in, slow_clock_pin_in, shutdown_pin, chip_reset_low, mosi, sck};
      sync2_r <= sync1_r;
   end
   assign sck_s = sync2_r[0];
   assign mosi_s = sync2_r[1];
   assign chip_reset_low_s = sync2_r[2];
   assign shut_s = sync2_r[3];
   assign slow_pin_s = sync2_r[4];
   assign osc_s = sync2_r[5];
   logic csn1_r, csn2_r;
   always_ff @(posedge clk_sys) begin
      csn1_r <= csn_low;
      csn2_r <= csn1_r;
   end
   assign csn_s = csn2_r;

   // Power sequencer state
   radio_port_pkg::power_state_t state_r, state_nxt;
   logic [21:0] step_cnt_r, step_cnt_nxt;
   logic rst_core;
   assign rst_core = reset || !chip_reset_low_s || state_r == radio_port_pkg::off_state;

   // Register file
   logic [7:0] regs_r [64];
   logic [7:0] regs_nxt [64];
   logic wr_en;
   logic [5:0] wr_addr;
   logic [7:0] wr_data;
   logic wake_hit, auto_sleep_hit;
   logic [2:0] evt;

   function automatic logic [2:0] lvl_of(input radio_port_pkg::power_state_t s);
      case (s)
         radio_port_pkg::active_state: return radio_port_pkg::LVL_ACTIVE;
         radio_port_pkg::idle_state: return radio_port_pkg::LVL_IDLE;
         radio_port_pkg::shallow_sleep_state: return radio_port_pkg::LVL_SHALLOW;
         radio_port_pkg::deep_sleep_state: return radio_port_pkg::LVL_DEEP;
         default: return radio_port_pkg::LVL_OFF;
      endcase
   endfunction

   // Register next values
   assign evt = {wake_hit, tx_done_evt, pkt_rx_evt};
   always_comb begin
      regs_nxt = regs_r;
      if (wr_en) begin
         regs_nxt[wr_addr] = wr_data;
      end
      if (wr_en && wr_addr == radio_port_pkg::ADDR_IRQ_ST) begin
         regs_nxt[radio_port_pkg::ADDR_IRQ_ST] = regs_r[radio_port_pkg::ADDR_IRQ_ST] & ~wr_data;
      end
      regs_nxt[radio_port_pkg::ADDR_IRQ_ST][2:0] = regs_nxt[radio_port_pkg::ADDR_IRQ_ST][2:0] | evt;
      regs_nxt[radio_port_pkg::ADDR_STATUS] = {5'h00, lvl_of(state_r)};
      if (auto_sleep_hit && regs_r[radio_port_pkg::ADDR_SLEEP][radio_port_pkg::SLEEP_AUTO_SLEEP]) begin
         regs_nxt[radio_port_pkg::ADDR_CTRL][2:0] =
            regs_r[radio_port_pkg::ADDR_SLEEP][radio_port_pkg::SLEEP_SLEEP_LSB +: 3];
      end
      if (wake_hit && regs_r[radio_port_pkg::ADDR_SLEEP][radio_port_pkg::SLEEP_AUTO_WAKE]) begin
         regs_nxt[radio_port_pkg::ADDR_CTRL][2:0] =
            regs_r[radio_port_pkg::ADDR_SLEEP][radio_port_pkg::SLEEP_WAKE_LSB +: 3];
      end
   end
   assign auto_sleep_hit = tx_done_evt || pkt_rx_evt;

   for (genvar i = 0; i < 64; i++) begin : g_reg
      always_ff @(posedge clk_sys) begin
         if (rst_core) begin
            regs_r[i] <= (i == 0) ? radio_port_pkg::CTRL_RST : radio_port_pkg::REG_RST;
         end else begin
            regs_r[i] <= regs_nxt[i];
         end
      end
   end

   // Timekeeper on the slow clock
   logic slow_d_r, tick;
   logic [15:0] tk_cnt_r, tk_cnt_nxt;
   logic [2:0] stable_r, stable_nxt;
   logic slow_sel;
   assign slow_sel = regs_r[radio_port_pkg::ADDR_CLK_CFG][radio_port_pkg::CLK_SLOW_IN] ? slow_pin_s : osc_s;
   assign tick = slow_sel && !slow_d_r;
   assign wake_hit = tick && tk_cnt_r == {regs_r[radio_port_pkg::ADDR_WAKE_CMP], 8'h00};
   always_comb begin
      tk_cnt_nxt = tick ? tk_cnt_r + 16'h0001 : tk_cnt_r;
      stable_nxt = stable_r;
      if (tick && stable_r != radio_port_pkg::SLOW_STABLE_TICKS) begin
         stable_nxt = stable_r + 3'h1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset || state_r == radio_port_pkg::off_state) begin
         slow_d_r <= 1'b0;
         tk_cnt_r <= 16'h0000;
         stable_r <= 3'h0;
      end else begin
         slow_d_r <= slow_sel;
         tk_cnt_r <= tk_cnt_nxt;
         stable_r <= stable_nxt;
      end
   end

   // Power sequencer
   logic [2:0] cur_lvl, tgt_lvl;
   logic [21:0] need;
   assign cur_lvl = lvl_of(state_r);
   assign tgt_lvl = (regs_r[radio_port_pkg::ADDR_CTRL][2:0] > radio_port_pkg::LVL_DEEP) ?
                    radio_port_pkg::LVL_DEEP : regs_r[radio_port_pkg::ADDR_CTRL][2:0];
   always_comb begin
      state_nxt = state_r;
      step_cnt_nxt = step_cnt_r + 22'h000001;
      case (state_r)
         radio_port_pkg::deep_sleep_state: need = T_DEEP_SHALLOW[21:0];
         radio_port_pkg::shallow_sleep_state: need = radio_port_pkg::T_SHALLOW_IDLE_CYC[21:0];
         radio_port_pkg::idle_state: need = radio_port_pkg::T_IDLE_ACTIVE_CYC[21:0];
         default: need = T_OFF_DEEP[21:0];
      endcase
      if (shut_s) begin
         state_nxt = radio_port_pkg::off_state;
         step_cnt_nxt = 22'h000000;
      end else begin
         case (state_r)
            radio_port_pkg::off_state: begin
               if (step_cnt_r >= need - 22'h000001) begin
                  state_nxt = radio_port_pkg::deep_sleep_state;
                  step_cnt_nxt = 22'h000000;
               end
            end
            radio_port_pkg::active_state, radio_port_pkg::idle_state,
            radio_port_pkg::shallow_sleep_state, radio_port_pkg::deep_sleep_state: begin
               if (tgt_lvl > cur_lvl) begin
                  state_nxt = radio_port_pkg::power_state_t'(cur_lvl + 3'h1);
                  step_cnt_nxt = 22'h000000;
               end else if (tgt_lvl == cur_lvl) begin
                  step_cnt_nxt = 22'h000000;
               end else if (step_cnt_r >= need - 22'h000001 &&
                            (state_r != radio_port_pkg::deep_sleep_state ||
                             stable_r == radio_port_pkg::SLOW_STABLE_TICKS)) begin
                  state_nxt = radio_port_pkg::power_state_t'(cur_lvl - 3'h1);
                  step_cnt_nxt = 22'h000000;
               end
            end
            default: state_nxt = radio_port_pkg::off_state;
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_r <= radio_port_pkg::off_state;
         step_cnt_r <= 22'h000000;
      end else begin
         state_r <= state_nxt;
         step_cnt_r <= step_cnt_nxt;
      end
   end

   // Serial slave
   logic link_en, sck_d_r, rise, fall;
   logic [2:0] bit_cnt_r, bit_cnt_nxt;
   logic in_cmd_r, in_cmd_nxt, done_r, done_nxt;
   radio_port_pkg::spi_cmd_t cmd_r, cmd_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt, rd_val;
   logic miso_nxt, push_nxt, pop_nxt;
   logic [7:0] tx_byte_nxt;
   assign link_en = chip_reset_low_s && state_r != radio_port_pkg::off_state;
   assign rise = sck_s && !sck_d_r;
   assign fall = !sck_s && sck_d_r;
   always_comb begin
      bit_cnt_nxt = bit_cnt_r;
      in_cmd_nxt = in_cmd_r;
      done_nxt = done_r;
      cmd_nxt = cmd_r;
      rx_sh_nxt = rx_sh_r;
      tx_sh_nxt = tx_sh_r;
      miso_nxt = miso;
      push_nxt = 1'b0;
      pop_nxt = 1'b0;
      tx_byte_nxt = tx_byte;
      wr_en = 1'b0;
      wr_addr = cmd_r.addr;
      wr_data = {rx_sh_r[6:0], mosi_s};
      rd_val = cmd_r.burst ? rx_byte : regs_r[cmd_r.addr];
      if (csn_s || !link_en) begin
         bit_cnt_nxt = 3'h0;
         in_cmd_nxt = 1'b1;
         done_nxt = 1'b0;
         miso_nxt = 1'b0;
      end else if (rise) begin
         rx_sh_nxt = {rx_sh_r[6:0], mosi_s};
         bit_cnt_nxt = bit_cnt_r + 3'h1;
         if (bit_cnt_r == 3'h7) begin
            if (in_cmd_r) begin
               cmd_nxt = radio_port_pkg::spi_cmd_t'(rx_sh_nxt);
               in_cmd_nxt = 1'b0;
            end else if (!done_r) begin
               done_nxt = !cmd_r.burst;
               if (cmd_r.write && cmd_r.burst) begin
                  push_nxt = 1'b1;
                  tx_byte_nxt = rx_sh_nxt;
               end else if (cmd_r.write && cmd_r.addr != radio_port_pkg::ADDR_STATUS) begin
                  wr_en = 1'b1;
               end else if (cmd_r.burst) begin
                  pop_nxt = 1'b1;
               end
            end
         end
      end else if (fall) begin
         if (in_cmd_r || done_r || cmd_r.write) begin
            miso_nxt = 1'b0;
         end else if (bit_cnt_r == 3'h0) begin
            miso_nxt = rd_val[7];
            tx_sh_nxt = {rd_val[6:0], 1'b0};
         end else begin
            miso_nxt = tx_sh_r[7];
            tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sck_d_r <= 1'b0;
         bit_cnt_r <= 3'h0;
         in_cmd_r <= 1'b1;
         done_r <= 1'b0;
         cmd_r <= '0;
         rx_sh_r <= 8'h00;
         tx_sh_r <= 8'h00;
         miso <= 1'b0;
         tx_push <= 1'b0;
         rx_pop <= 1'b0;
         tx_byte <= 8'h00;
      end else begin
         sck_d_r <= sck_s;
         bit_cnt_r <= bit_cnt_nxt;
         in_cmd_r <= in_cmd_nxt;
         done_r <= done_nxt;
         cmd_r <= cmd_nxt;
         rx_sh_r <= rx_sh_nxt;
         tx_sh_r <= tx_sh_nxt;
         miso <= miso_nxt;
         tx_push <= push_nxt;
         rx_pop <= pop_nxt;
         tx_byte <= tx_byte_nxt;
      end
   end

   // Pin and status outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq <= 1'b0;
         slow_clock_pin_out <= 1'b0;
         fast_clock_pin_out <= 1'b0;
         slow_clock_pin_oe_n <= 1'b0;
         fast_clock_pin_oe_n <= 1'b0;
         power_level <= radio_port_pkg::LVL_OFF;
         rail_1v_on <= 1'b0;
      end else begin
         irq <= |(regs_r[radio_port_pkg::ADDR_IRQ_ST] & regs_r[radio_port_pkg::ADDR_IRQ_EN]);
         slow_clock_pin_out <= 1'b0;
         fast_clock_pin_out <= 1'b0;
         slow_clock_pin_oe_n <= regs_nxt[radio_port_pkg::ADDR_CLK_CFG][radio_port_pkg::CLK_SLOW_IN] && !rst_core;
         fast_clock_pin_oe_n <= regs_nxt[radio_port_pkg::ADDR_CLK_CFG][radio_port_pkg::CLK_FAST_IN] && !rst_core;
         power_level <= lvl_of(state_nxt);
         rail_1v_on <= state_nxt == radio_port_pkg::idle_state || state_nxt == radio_port_pkg::active_state;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   chk_miso_idle: assert property (csn_s |=> !miso) else $error("miso active while deselected");
   chk_off_silent: assert property (state_r == radio_port_pkg::off_state |=> !tx_push && !rx_pop)
      else $error("serial traffic in off state");
   chk_no_skip: assert property (!shut_s && state_r != radio_port_pkg::off_state && state_nxt != state_r
      |=> lvl_of(state_r) == $past(cur_lvl) + 3'h1 || lvl_of(state_r) + 3'h1 == $past(cur_lvl))
      else $error("power level skipped");
   chk_shut_off: assert property (shut_s |=> state_r == radio_port_pkg::off_state)
      else $error("power-off pin ignored");
   chk_rail_state: assert property (rail_1v_on == (state_r == radio_port_pkg::idle_state ||
      state_r == radio_port_pkg::active_state)) else $error("rail on outside idle or active");
   chk_pins_ground: assert property (!regs_r[radio_port_pkg::ADDR_CLK_CFG][radio_port_pkg::CLK_SLOW_IN]
      |-> !slow_clock_pin_oe_n && !slow_clock_pin_out) else $error("slow clock pin not grounded");
   chk_write_store: assert property (wr_en && !rst_core && wr_addr != radio_port_pkg::ADDR_IRQ_ST
      |=> regs_r[$past(wr_addr)] == $past(wr_data))
      else $error("write not stored");
   chk_deep_stable: assert property (state_r == radio_port_pkg::deep_sleep_state ##1
      state_r == radio_port_pkg::shallow_sleep_state |-> $past(stable_r) == radio_port_pkg::SLOW_STABLE_TICKS)
      else $error("left deep sleep on unstable clock");
   chk_irq_follow: assert property ((regs_r[radio_port_pkg::ADDR_IRQ_ST] &
      regs_r[radio_port_pkg::ADDR_IRQ_EN]) != 8'h00 |=> irq) else $error("enabled event missed");
   chk_reset_regs: assert property (!chip_reset_low_s |=> regs_r[radio_port_pkg::ADDR_CTRL] == radio_port_pkg::CTRL_RST)
      else $error("chip reset left registers");
   chk_single_byte: assert property (done_r && !csn_s |=> !wr_en && !tx_push) else $error("extra byte taken");
   cov_reg_write: cover property (wr_en && !rst_core);
   cov_burst_push: cover property (tx_push);
   cov_burst_pop: cover property (rx_pop);
   cov_wake: cover property (state_r == radio_port_pkg::shallow_sleep_state ##1 state_r == radio_port_pkg::idle_state);
endmodule

`default_nettype wire

/* verilog/radio_port_pkg.sv */
// Constants, types and timing figures for the radio host serial port
package radio_port_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Power-step times in their own units
   localparam int T_OFF_DEEP_MS = 20;
   localparam int T_DEEP_SHALLOW_MS = 3;
   localparam int T_SHALLOW_IDLE_US = 16;
   localparam int T_IDLE_ACTIVE_NS = 500;
   localparam int T_OFF_DEEP_CYC = T_OFF_DEEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int T_DEEP_SHALLOW_CYC = T_DEEP_SHALLOW_MS * 1000000 / CLK_PERIOD_NS;
   localparam int T_SHALLOW_IDLE_CYC = T_SHALLOW_IDLE_US * 1000 / CLK_PERIOD_NS;
   localparam int T_IDLE_ACTIVE_CYC = T_IDLE_ACTIVE_NS / CLK_PERIOD_NS;
   localparam logic [2:0] SLOW_STABLE_TICKS = 3'h4;
   // Register addresses
   localparam logic [5:0] ADDR_CTRL = 6'h00;
   localparam logic [5:0] ADDR_SLEEP = 6'h01;
   localparam logic [5:0] ADDR_IRQ_EN = 6'h02;
   localparam logic [5:0] ADDR_IRQ_ST = 6'h03;
   localparam logic [5:0] ADDR_CLK_CFG = 6'h04;
   localparam logic [5:0] ADDR_WAKE_CMP = 6'h05;
   localparam logic [5:0] ADDR_STATUS = 6'h06;
   // Field positions
   localparam int SLEEP_WAKE_LSB = 0;
   localparam int SLEEP_SLEEP_LSB = 3;
   localparam int SLEEP_AUTO_SLEEP = 6;
   localparam int SLEEP_AUTO_WAKE = 7;
   localparam int CLK_SLOW_IN = 0;
   localparam int CLK_FAST_IN = 1;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h03;
   localparam logic [7:0] REG_RST = 8'h00;
   // Power levels, 0 is the most awake
   localparam logic [2:0] LVL_ACTIVE = 3'h0;
   localparam logic [2:0] LVL_IDLE = 3'h1;
   localparam logic [2:0] LVL_SHALLOW = 3'h2;
   localparam logic [2:0] LVL_DEEP = 3'h3;
   localparam logic [2:0] LVL_OFF = 3'h4;

   typedef enum logic [2:0] {active_state, idle_state, shallow_sleep_state, deep_sleep_state, off_state} power_state_t;

   typedef struct packed {
      logic burst;
      logic write;
      logic [5:0] addr;
   } spi_cmd_t;
endpackage

/* verif/spi_host_model.sv */
// Serial master model standing in for the host microcontroller
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Serial pins
   output logic csn_low,
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   localparam real HALF_NS = 62.5;
   initial begin
      csn_low = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end
   // Frame start, clock stands low
   task automatic open_f();
      csn_low = 1'b0;
      #(HALF_NS);
   endtask
   // One byte, most significant bit first
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         #(HALF_NS);
         sck = 1'b1;
         rx[i] = miso;
         #(HALF_NS);
         sck = 1'b0;
      end
   endtask
   // Frame end, released data line flips
   task automatic close_f();
      #(HALF_NS);
      csn_low = 1'b1;
      mosi = ~mosi;
      #(4 * HALF_NS);
   endtask
endmodule
`default_nettype wire

/* verif/tb_radio_host_spi_port.sv */
// Testbench for the radio host serial port
`timescale 1ns/1ps
`default_nettype none
module tb_radio_host_spi_port;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic chip_reset_low = 1'b0;
   logic shutdown_pin = 1'b1;
   logic csn_low, sck, mosi, miso, irq;
   logic slow_out, slow_oe_n, fast_out, fast_oe_n;
   logic slow_osc_in = 1'b0;
   logic [3:0] osc_cnt = 4'h0;
   logic pkt_rx_evt = 1'b0;
   logic tx_done_evt = 1'b0;
   logic [7:0] tx_byte;
   logic tx_push, rx_pop;
   logic [7:0] rx_byte = 8'ha1;
   logic [2:0] power_level, prev_lvl;
   logic rail_1v_on;
   logic [7:0] push_q[$];
   logic [7:0] x;
   int n_mismatch = 0;
   int tests_run = 0;
   int n_pop = 0;
   int n;
   always #5 clk_sys = ~clk_sys;
   spi_host_model i_host (.csn_low(csn_low), .sck(sck), .mosi(mosi), .miso(miso));
   radio_host_spi_port #(.T_OFF_DEEP(20), .T_DEEP_SHALLOW(100)) i_dut (
      .clk_sys(clk_sys), .reset(reset), .chip_reset_low(chip_reset_low), .shutdown_pin(shutdown_pin),
      .csn_low(csn_low), .sck(sck), .mosi(mosi), .miso(miso), .irq(irq),
      .slow_clock_pin_in(slow_osc_in), .slow_clock_pin_out(slow_out), .slow_clock_pin_oe_n(slow_oe_n),
      .fast_clock_pin_in(1'b0), .fast_clock_pin_out(fast_out), .fast_clock_pin_oe_n(fast_oe_n),
      .slow_osc_in(slow_osc_in), .pkt_rx_evt(pkt_rx_evt), .tx_done_evt(tx_done_evt),
      .tx_byte(tx_byte), .tx_push(tx_push), .rx_byte(rx_byte), .rx_pop(rx_pop),
      .power_level(power_level), .rail_1v_on(rail_1v_on));
   // Slow oscillator and receive FIFO stand-in
   always @(posedge clk_sys) begin
      osc_cnt <= osc_cnt + 4'h1;
      slow_osc_in <= osc_cnt[3];
      if (tx_push === 1'b1) push_q.push_back(tx_byte);
      if (rx_pop === 1'b1) begin
         rx_byte <= rx_byte + 8'h01;
         n_pop++;
      end
   end
   // Power steps move one level, except into or out of off
   always @(posedge clk_sys) begin
      prev_lvl <= power_level;
      if (!reset && prev_lvl !== power_level && power_level !== 3'h4 && prev_lvl !== 3'h4 &&
          (power_level - prev_lvl) !== 3'h1 && (prev_lvl - power_level) !== 3'h1) begin
         n_mismatch++;
         $display("[FAIL] %0t level jump %0d to %0d", $time, prev_lvl, power_level);
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] r;
      i_host.open_f();
      i_host.xbyte({2'b01, a}, r);
      i_host.xbyte(d, r);
      i_host.close_f();
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      logic [7:0] r;
      i_host.open_f();
      i_host.xbyte({2'b00, a}, r);
      i_host.xbyte(8'h00, d);
      i_host.close_f();
   endtask
   task automatic wait_lvl(input logic [2:0] lvl, input int max, output int cyc);
      cyc = 0;
      while (power_level !== lvl && cyc < max) begin
         @(posedge clk_sys);
         cyc++;
      end
      chk({5'h0, power_level}, {5'h0, lvl}, "power level");
   endtask
   task automatic pulse_rst();
      @(posedge clk_sys);
      chip_reset_low <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chip_reset_low <= 1'b1;
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic results();
      $display("Counts: %0d comparisons, %0d mismatches", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({5'h0, power_level}, 8'h04, "off after reset");
      chk({6'h0, slow_oe_n, fast_oe_n}, 8'h00, "pins grounded");
      wr(radio_port_pkg::ADDR_WAKE_CMP, 8'h5a);
      @(posedge clk_sys);
      chip_reset_low <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wr(radio_port_pkg::ADDR_WAKE_CMP, 8'h5b);
      @(posedge clk_sys);
      chip_reset_low <= 1'b0;
      shutdown_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chip_reset_low <= 1'b1;
      wait_lvl(3'h3, 200, n);
      repeat (6) @(posedge clk_sys);
      rd(radio_port_pkg::ADDR_WAKE_CMP, x);
      chk(x, 8'h00, "ignored frames");
      $display("Test startup done");
      for (int a = 0; a < 6; a++) begin
         rd(a[5:0], x);
         chk(x, (a == 0) ? radio_port_pkg::CTRL_RST : (a == 3) ? 8'h04 : radio_port_pkg::REG_RST, "default");
      end
      rd(radio_port_pkg::ADDR_STATUS, x);
      chk(x, 8'h03, "status deep");
      wr(radio_port_pkg::ADDR_WAKE_CMP, 8'ha5);
      wr(radio_port_pkg::ADDR_STATUS, 8'h00);
      rd(radio_port_pkg::ADDR_WAKE_CMP, x);
      chk(x, 8'ha5, "write read");
      rd(radio_port_pkg::ADDR_STATUS, x);
      chk(x, 8'h03, "read-only status");
      i_host.open_f();
      i_host.xbyte(8'h45, x);
      i_host.xbyte(8'h3c, x);
      i_host.xbyte(8'h99, x);
      i_host.close_f();
      rd(radio_port_pkg::ADDR_WAKE_CMP, x);
      chk(x, 8'h3c, "third byte ignored");
      $display("Test registers done");
      wr(radio_port_pkg::ADDR_CTRL, 8'h00);
      wait_lvl(3'h2, 400, n);
      chk({7'h0, n >= 50}, 8'h01, "deep wake time");
      wait_lvl(3'h1, 1700, n);
      chk({7'h0, n >= 1590}, 8'h01, "shallow wake time");
      chk({7'h0, rail_1v_on}, 8'h01, "rail idle");
      wait_lvl(3'h0, 60, n);
      chk({7'h0, n >= 45}, 8'h01, "idle wake time");
      wr(radio_port_pkg::ADDR_CTRL, 8'h03);
      wait_lvl(3'h3, 10, n);
      chk({7'h0, rail_1v_on}, 8'h00, "rail deep");
      $display("Test power done");
      wr(radio_port_pkg::ADDR_IRQ_EN, 8'h01);
      @(posedge clk_sys);
      tx_done_evt <= 1'b1;
      @(posedge clk_sys);
      tx_done_evt <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({7'h0, irq}, 8'h00, "masked event");
      pkt_rx_evt <= 1'b1;
      @(posedge clk_sys);
      pkt_rx_evt <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({7'h0, irq}, 8'h01, "enabled event");
      wr(radio_port_pkg::ADDR_IRQ_ST, 8'h01);
      chk({7'h0, irq}, 8'h00, "cleared");
      rd(radio_port_pkg::ADDR_IRQ_ST, x);
      chk(x, 8'h06, "masked status kept");
      $display("Test interrupt done");
      i_host.open_f();
      i_host.xbyte(8'hc0, x);
      push_q.delete();
      for (int i = 1; i <= 3; i++) i_host.xbyte(8'(i * 8'h11), x);
      i_host.close_f();
      chk(8'(push_q.size()), 8'h03, "push count");
      for (int i = 0; i < push_q.size(); i++) chk(push_q[i], 8'((i + 1) * 8'h11), "pushed");
      n_pop = 0;
      i_host.open_f();
      i_host.xbyte(8'h80, x);
      for (int i = 0; i < 3; i++) begin
         i_host.xbyte(8'h00, x);
         chk(x, 8'ha1 + 8'(i), "burst read");
      end
      i_host.close_f();
      chk(8'(n_pop), 8'h03, "pop count");
      $display("Test burst done");
      wr(radio_port_pkg::ADDR_CLK_CFG, 8'h01);
      chk({6'h0, slow_oe_n, fast_oe_n}, 8'h02, "slow input");
      wr(radio_port_pkg::ADDR_CLK_CFG, 8'h03);
      chk({6'h0, slow_oe_n, fast_oe_n}, 8'h03, "both inputs");
      chk({6'h0, slow_out, fast_out}, 8'h00, "pin drive low");
      pulse_rst();
      chk({6'h0, slow_oe_n, fast_oe_n}, 8'h00, "pins regrounded");
      rd(radio_port_pkg::ADDR_CTRL, x);
      chk(x, 8'h03, "ctrl after reset");
      rd(radio_port_pkg::ADDR_WAKE_CMP, x);
      chk(x, 8'h00, "reg after reset");
      @(posedge clk_sys);
      shutdown_pin <= 1'b1;
      wait_lvl(3'h4, 20, n);
      chk({7'h0, rail_1v_on}, 8'h00, "rail off");
      $display("Test reset and shutdown done");
      results();
   end
endmodule
`default_nettype wire
